// ==== src/iex_pkg.sv ====
package iex_pkg;
   localparam int          DATA_W     = 12;
   localparam int          CNT_W      = 4;
   localparam int          FIFO_DEPTH = 8;
   localparam logic [3:0]  LAST_BIT   = 4'hc;
   localparam logic [3:0]  WAKE_FALLS = 4'hc;
   localparam logic [3:0]  CNT_RST    = 4'h0;
   localparam logic [11:0] SR_RST     = 12'h000;

   typedef enum logic [1:0] {
      IEX_UNKNOWN,
      IEX_IDLE,
      IEX_LOAD,
      IEX_SHIFT
   } iex_state_e;
endpackage : iex_pkg

// ==== src/iex_expander.sv ====
`timescale 1ns/100ps

module iex_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,        // System clock
   input  wire logic             sys_rst,    // Synchronous reset
   input  wire logic [WIDTH-1:0] in_data,    // Word to store
   input  wire logic             in_valid,   // Word offered
   output logic                  in_ready,   // Room available
   output logic      [WIDTH-1:0] out_data,   // Oldest word
   output logic                  out_valid,  // Oldest word present
   input  wire logic             out_ready   // Drain accepts word
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   wire              push_w = in_valid && in_ready;
   wire              pop_w  = out_valid && out_ready;

   assign in_ready  = (count_r != (AW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign out_data  = mem_r[rd_ptr_r];

   always_ff @(posedge clk) begin
      if (push_w) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push_w) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop_w) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         count_r <= count_r + (AW+1)'(push_w) - (AW+1)'(pop_w);
      end
   end
endmodule : iex_fifo

module iex_expander #(
   parameter int DATA_W = iex_pkg::DATA_W,
   parameter int DEPTH  = iex_pkg::FIFO_DEPTH
) (
   input  wire logic              clk,              // 10 MHz system clock
   input  wire logic              sys_rst,          // Synchronous reset, high
   input  wire logic              shift_clk,        // Host shift clock pin
   input  wire logic              line_in,          // Shared line, level seen
   output logic                   line_out,         // Shared line, level driven
   output logic                   line_oe,          // Shared line, high while driving
   input  wire logic [DATA_W-1:0] parallel_inputs   // Parallel inputs
);
   iex_pkg::iex_state_e state_r;
   iex_pkg::iex_state_e state_nxt;

   logic              sck_s1_r, sck_s2_r, sck_s3_r;
   logic              lin_s1_r, lin_s2_r, lin_s3_r;
   logic [DATA_W-1:0] par_s1_r, par_s2_r;
   logic [DATA_W-1:0] sr_r;
   logic [3:0]        cnt_r;
   logic              line_out_r, line_oe_r;
   logic [DATA_W-1:0] fifo_data;
   logic              fifo_valid, fifo_in_ready;

   // Edge detectors look only at the second and third stages
   wire clk_fall_w  = sck_s3_r && !sck_s2_r;
   wire line_fall_w = lin_s3_r && !lin_s2_r;
   wire in_mode_w   = (state_r == iex_pkg::IEX_IDLE);
   wire capture_w   = in_mode_w && line_fall_w && sck_s2_r && fifo_in_ready;
   wire fifo_pop_w  = (state_r == iex_pkg::IEX_LOAD);
   wire load_w      = fifo_pop_w && fifo_valid;
   wire last_w      = (cnt_r == iex_pkg::LAST_BIT);
   wire wake_w      = (cnt_r == iex_pkg::WAKE_FALLS);
   // Clock falls qualified by the state that acts on them
   wire wake_fall_w  = (state_r == iex_pkg::IEX_UNKNOWN) && clk_fall_w;
   wire shift_fall_w = (state_r == iex_pkg::IEX_SHIFT) && clk_fall_w;

   assign line_out = line_out_r;
   assign line_oe  = line_oe_r;

   iex_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .in_data   (par_s2_r),
      .in_valid  (capture_w),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop_w)
   );

   // Parallel inputs ride two stages, as the line does up to lin_s2_r where its fall is seen, so the word taken
   // at capture is the one standing while the host still holds the inputs
   always_ff @(posedge clk) begin
      sck_s1_r <= shift_clk;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
      lin_s1_r <= line_in;
      lin_s2_r <= lin_s1_r;
      lin_s3_r <= lin_s2_r;
      par_s1_r <= parallel_inputs;
      par_s2_r <= par_s1_r;
   end

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         iex_pkg::IEX_UNKNOWN: if (clk_fall_w && wake_w) state_nxt = iex_pkg::IEX_IDLE;
         iex_pkg::IEX_IDLE:    if (capture_w) state_nxt = iex_pkg::IEX_LOAD;
         iex_pkg::IEX_LOAD:    if (fifo_valid) state_nxt = iex_pkg::IEX_SHIFT;
         iex_pkg::IEX_SHIFT:   if (clk_fall_w && last_w) state_nxt = iex_pkg::IEX_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_r    <= iex_pkg::IEX_UNKNOWN;
         cnt_r      <= iex_pkg::CNT_RST;
         sr_r       <= iex_pkg::SR_RST;
         line_out_r <= 1'b1;
         line_oe_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (wake_fall_w) begin
            cnt_r <= wake_w ? iex_pkg::CNT_RST : cnt_r + 4'h1;
         end
         if (capture_w) begin
            cnt_r      <= iex_pkg::CNT_RST;
            line_oe_r  <= 1'b1;
            line_out_r <= 1'b0;
         end
         if (load_w) begin
            sr_r <= fifo_data;
         end
         if (shift_fall_w) begin
            cnt_r <= last_w ? iex_pkg::CNT_RST : cnt_r + 4'h1;
            if (last_w) begin
               line_oe_r  <= 1'b0;
               line_out_r <= 1'b1;
            end else begin
               line_out_r <= sr_r[0];
               sr_r       <= {1'b0, sr_r[DATA_W-1:1]};
            end
         end
      end
   end

   // Wake, capture, load, shift and release checks
   sequence s_capture;
      capture_w;
   endsequence

   sequence s_drive_low;
      line_oe_r && !line_out_r;
   endsequence

   a_capture_drive: assert property (@(posedge clk) disable iff (sys_rst)
      s_capture |=> s_drive_low ##1 s_drive_low)
      else $error("line not driven low after capture");
   a_capture_word: assert property (@(posedge clk) disable iff (sys_rst)
      s_capture |=> ##1 (sr_r == $past(par_s2_r, 2)))
      else $error("captured word not loaded");
   a_shift_bit: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == iex_pkg::IEX_SHIFT && clk_fall_w && !last_w) |=> (line_out_r == $past(sr_r[0])) && line_oe_r)
      else $error("wrong bit presented");
   a_shift_reg: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == iex_pkg::IEX_SHIFT && clk_fall_w && !last_w) |=> (sr_r == ($past(sr_r) >> 1)))
      else $error("shift register did not shift");
   a_release_13th: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == iex_pkg::IEX_SHIFT && clk_fall_w && last_w) |=> !line_oe_r && in_mode_w)
      else $error("line not released on thirteenth fall");
   a_hold_drive: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == iex_pkg::IEX_SHIFT) |-> line_oe_r)
      else $error("line released early");
   a_wake_count: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == iex_pkg::IEX_UNKNOWN && clk_fall_w && wake_w) |=> in_mode_w && !line_oe_r)
      else $error("no input mode after thirteen falls");
   a_quiet_unknown: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == iex_pkg::IEX_UNKNOWN || in_mode_w) |-> !line_oe_r)
      else $error("line driven in input mode");
   a_early_wake: assert property (@(posedge clk) disable iff (sys_rst)
      (wake_fall_w && !wake_w) |=> (state_r == iex_pkg::IEX_UNKNOWN) && !line_oe_r)
      else $error("input mode entered before thirteen falls");
   a_refuse_low: assert property (@(posedge clk) disable iff (sys_rst)
      (in_mode_w && line_fall_w && !sck_s2_r) |=> in_mode_w && !line_oe_r)
      else $error("capture taken with clock low");
   a_load_next: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == iex_pkg::IEX_LOAD) |=> (state_r == iex_pkg::IEX_SHIFT))
      else $error("captured word not moved to shift register");
   a_load_low: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == iex_pkg::IEX_LOAD) |-> line_oe_r && !line_out_r)
      else $error("line not low while loading");
   a_count_start: assert property (@(posedge clk) disable iff (sys_rst)
      s_capture |=> (cnt_r == iex_pkg::CNT_RST))
      else $error("bit count not cleared at capture");
   a_hold_bit: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == iex_pkg::IEX_SHIFT && !clk_fall_w) |=> $stable(line_out_r))
      else $error("bit changed without clock fall");
endmodule : iex_expander

// ==== verif/iex_host.sv ====
`timescale 1ns/100ps
module iex_host (
   input  wire logic clk,       // System clock
   input  wire logic line,      // Resolved line
   output logic      shift_clk, // Shift clock pin
   output logic      host_oe,   // High while host drives
   output logic      host_out   // Level host drives
);
   initial begin
      shift_clk = 1'b1;
      host_oe   = 1'b0;
      host_out  = 1'b1;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask : hold
   task automatic fall_rise();
      shift_clk <= 1'b0;
      hold(6);
      shift_clk <= 1'b1;
      hold(6);
   endtask : fall_rise
   task automatic wake(input int n);
      repeat (n) fall_rise();
   endtask : wake
   task automatic strobe(input logic lvl);
      shift_clk <= lvl;
      hold(6);
      host_out  <= 1'b0;
      host_oe   <= 1'b1;
      hold(6);
      host_oe   <= 1'b0;
      host_out  <= 1'b1;
      hold(6);
   endtask : strobe
   task automatic shift(output logic [11:0] word);
      for (int k = 0; k < 13; k++) begin
         shift_clk <= 1'b0;
         hold(6);
         if (k < 12) word[k] = line;
         shift_clk <= 1'b1;
         hold(6);
      end
   endtask : shift
endmodule : iex_host

// ==== verif/iex_expander_tb.sv ====
`timescale 1ns/100ps
module iex_expander_tb;
   logic        clk;
   logic        sys_rst;
   logic        line_out;
   logic        line_oe;
   logic [11:0] parallel_inputs;
   logic        shift_clk;
   logic        host_oe;
   logic        host_out;
   wire  logic  line;
   int          err_count;
   int          cmp_count;
   int          cycles;
   logic [11:0] word;
   // Pull-up when nobody drives
   assign line = line_oe ? line_out : (host_oe ? host_out : 1'b1);
   iex_expander i_dut (.clk(clk), .sys_rst(sys_rst), .shift_clk(shift_clk), .line_in(line),
      .line_out(line_out), .line_oe(line_oe), .parallel_inputs(parallel_inputs));
   iex_host i_host (.clk(clk), .line(line), .shift_clk(shift_clk), .host_oe(host_oe),
      .host_out(host_out));
   task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic finish_test();
      $display("Compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test
   task automatic t_power_up();
      chk("oe in reset", 12'h000, {11'h000, line_oe});
      i_host.wake(12);
      i_host.strobe(1'b1);
      chk("oe before wake", 12'h000, {11'h000, line_oe});
      i_host.wake(1);
      i_host.strobe(1'b0);
      chk("oe on clock low", 12'h000, {11'h000, line_oe});
   endtask : t_power_up
   task automatic t_access(input logic [11:0] pat);
      parallel_inputs <= pat;
      i_host.strobe(1'b1);
      parallel_inputs <= ~pat;
      chk("drive low", 12'h002, {10'h000, line_oe, line});
      i_host.shift(word);
      chk("word", pat, word);
      chk("release", 12'h000, {11'h000, line_oe});
   endtask : t_access
   task automatic t_mid_reset(input logic [11:0] pat);
      parallel_inputs <= pat;
      i_host.strobe(1'b1);
      chk("drive before reset", 12'h001, {11'h000, line_oe});
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      chk("oe after reset", 12'h000, {11'h000, line_oe});
      i_host.wake(13);
      t_access(pat);
   endtask : t_mid_reset
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         err_count++;
         finish_test();
      end
   end
   initial begin
      err_count       = 0;
      cmp_count       = 0;
      cycles          = 0;
      sys_rst         = 1'b1;
      parallel_inputs = 12'h000;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      t_power_up();
      t_access(12'ha5c);
      t_access(12'h001);
      t_access(12'h800);
      t_mid_reset(12'h3c6);
      finish_test();
   end
endmodule : iex_expander_tb
